// [iss_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module iss_status_regs (
  // clock and reset
  input  wire logic                    CLOCK,
  input  wire logic                    RSTN,
  // measurement commands
  input  wire logic                    INIT_CMD,
  input  wire logic                    MEAS_START,
  // overload pulses
  input  wire logic                    VOLT_OVLD,
  input  wire logic                    CURR_OVLD,
  input  wire logic                    FREQ_OVLD,
  input  wire logic                    CAP_OVLD,
  input  wire logic                    RES_OVLD,
  input  wire logic                    TEMP_OVLD,
  // questionable conditions
  input  wire logic                    CAL_CORRUPT,
  input  wire logic                    LOWER_LIMIT_FAIL,
  input  wire logic                    MEM_OVERFLOW,
  // operation conditions
  input  wire logic                    CALIBRATING,
  input  wire logic                    SELF_TEST,
  input  wire logic                    SCANNING,
  input  wire logic                    WAIT_TRIG,
  input  wire logic                    MSD_DETECTED,
  input  wire logic                    LOCKED,
  input  wire logic                    ERR_QUEUE_NE,
  input  wire logic                    PANEL_CFG_CHANGE,
  input  wire logic                    REMOTE_CFG_CHANGE,
  input  wire logic [iss_pkg::CNT_W-1:0] STORED_COUNT,
  input  wire logic [iss_pkg::CNT_W-1:0] READING_COUNT_THRESHOLD_SETTING,
  // alarm sources
  input  wire logic [3:0]              ALARM_EVT,
  input  wire logic                    ALARM_QUEUE_NE,
  input  wire logic                    ALARM_QUEUE_OVF,
  input  wire logic [2:0]              ALARM_TRIGGERED,
  // register access
  input  wire logic                    RD_STB,
  input  wire logic [1:0]              RD_GROUP,
  input  wire logic [1:0]              RD_VIEW,
  output logic      [iss_pkg::GW-1:0]  RD_DATA,
  output logic                         RD_VALID,
  input  wire logic                    WR_STB,
  input  wire logic [1:0]              WR_GROUP,
  input  wire logic [iss_pkg::GW-1:0]  WR_DATA,
  input  wire logic                    CLS_STB,
  // summary bits
  output logic                         SUM_QUES,
  output logic                         SUM_OPER,
  output logic                         SUM_ALRM
);
  import iss_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] grp_mask(input logic [1:0] g);
    logic [15:0] m;
    m = 16'h0000;
    unique case (g)
      GRP_QUES: m = MASK_QUES;
      GRP_OPER: m = MASK_OPER;
      GRP_ALRM: m = MASK_ALRM;
      default:  m = 16'h0000;
    endcase
    return m;
  endfunction : grp_mask

  function automatic logic [15:0] cond_mask(input logic [1:0] g);
    logic [15:0] m;
    m = 16'h0000;
    unique case (g)
      GRP_QUES: m = COND_QUES;
      GRP_OPER: m = COND_OPER;
      GRP_ALRM: m = COND_ALRM;
      default:  m = 16'h0000;
    endcase
    return m;
  endfunction : cond_mask

  iss_state_t       st_reg;
  iss_state_t       st_next;
  logic [2:0][15:0] cond;
  logic [2:0][15:0] evp;
  logic [2:0][15:0] set;
  logic [2:0][15:0] clr;
  logic [5:0]       ovp;
  logic             over_thr;

  // ----------------------------------------
  // live conditions
  // ----------------------------------------
  assign over_thr = STORED_COUNT > READING_COUNT_THRESHOLD_SETTING;

  // built from inputs, and from the registered panel flag for bit 8, so a condition read is never stale
  always_comb begin
    cond        = '0;
    cond[0][8]  = CAL_CORRUPT;
    cond[0][11] = LOWER_LIMIT_FAIL;
    cond[0][12] = MEM_OVERFLOW;
    cond[1][0]  = CALIBRATING;
    cond[1][1]  = SELF_TEST;
    cond[1][4]  = SCANNING;
    cond[1][5]  = WAIT_TRIG;
    cond[1][7]  = MSD_DETECTED;
    cond[1][8]  = st_reg.cfg_panel;
    cond[1][9]  = over_thr;
    cond[1][10] = LOCKED;
    cond[1][13] = ERR_QUEUE_NE;
    cond[2][4]  = ALARM_QUEUE_NE;
    cond[2][8:6] = ALARM_TRIGGERED;
  end

  // ----------------------------------------
  // event-only sources
  // ----------------------------------------
  assign ovp = {TEMP_OVLD, RES_OVLD, CAP_OVLD, FREQ_OVLD, CURR_OVLD, VOLT_OVLD} & st_reg.arm;

  always_comb begin
    evp         = '0;
    evp[0][0]   = ovp[0];
    evp[0][1]   = ovp[1];
    evp[0][5]   = ovp[2];
    evp[0][7]   = ovp[3];
    evp[0][9]   = ovp[4];
    evp[0][10]  = ovp[5];
    evp[1][11]  = PANEL_CFG_CHANGE | REMOTE_CFG_CHANGE;
    evp[2][3:0] = ALARM_EVT;
    evp[2][5]   = ALARM_QUEUE_OVF;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    set = '0;
    clr = '0;
    st_next.rd_valid = 1'b0;
    for (int g = 0; g < 3; g++) begin
      set[g] = ((cond[g] & ~st_reg.prev[g]) | evp[g]) & grp_mask(2'(g));
      st_next.prev[g] = cond[g];
    end
    if (CLS_STB) begin
      clr = '1;
    end
    if (RD_STB) begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data = 16'h0000;
      if (RD_GROUP != 2'h3) begin
        unique case (RD_VIEW)
          VIEW_COND:   st_next.rd_data = cond[RD_GROUP] & cond_mask(RD_GROUP);
          VIEW_EVENT: begin
            st_next.rd_data = st_reg.ev[RD_GROUP];
            clr[RD_GROUP] = '1;
          end
          VIEW_ENABLE: st_next.rd_data = st_reg.en[RD_GROUP];
          default:     st_next.rd_data = 16'h0000;
        endcase
      end
    end
    // a set in the clearing cycle survives
    for (int g = 0; g < 3; g++) begin
      st_next.ev[g] = (st_reg.ev[g] & ~clr[g]) | set[g];
    end
    if (WR_STB && WR_GROUP != 2'h3) begin
      st_next.en[WR_GROUP] = WR_DATA & grp_mask(WR_GROUP);
    end
    // once fired, an overload waits for the next initiate
    if (INIT_CMD) begin
      st_next.arm = RST_ARM;
    end else begin
      st_next.arm = st_reg.arm & ~ovp;
    end
    // a panel change landing with a command is kept, so no edit goes unreported
    if (PANEL_CFG_CHANGE) begin
      st_next.cfg_panel = 1'b1;
    end else if (MEAS_START || INIT_CMD) begin
      st_next.cfg_panel = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg.ev        <= '0;
      st_reg.en        <= {3{RST_ENABLE}};
      st_reg.prev      <= '0;
      st_reg.arm       <= RST_ARM;
      st_reg.cfg_panel <= 1'b0;
      st_reg.rd_data   <= 16'h0000;
      st_reg.rd_valid  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RD_DATA  = st_reg.rd_data;
  assign RD_VALID = st_reg.rd_valid;
  assign SUM_QUES = |(st_reg.ev[0] & st_reg.en[0]);
  assign SUM_OPER = |(st_reg.ev[1] & st_reg.en[1]);
  assign SUM_ALRM = |(st_reg.ev[2] & st_reg.en[2]);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  sequence s_volt_spent;
    !st_reg.arm[0] && !st_reg.ev[0][0] && !INIT_CMD;
  endsequence

  sequence s_cond_read(logic [1:0] g);
    RD_STB && RD_VIEW == VIEW_COND && RD_GROUP == g;
  endsequence

  sequence s_ovl_armed(logic hit, logic armed);
    hit && armed;
  endsequence

  // the panel flag takes one cycle, its event a second
  sequence s_panel_first;
    PANEL_CFG_CHANGE && !st_reg.cfg_panel;
  endsequence

  sequence s_panel_flagged;
    st_reg.cfg_panel ##1 st_reg.ev[1][8];
  endsequence

  a_ovl_once_init: assert property (s_volt_spent |=> !st_reg.ev[0][0])
    else $error("voltage overload re-set without initiate");
  a_volt_latch: assert property (VOLT_OVLD && st_reg.arm[0]
                                 |=> st_reg.ev[0][0] && st_reg.arm[0] == $past(INIT_CMD))
    else $error("voltage overload not latched");
  a_freq_latch: assert property (FREQ_OVLD && st_reg.arm[2] |=> st_reg.ev[0][5])
    else $error("frequency overload not latched");
  a_ques_evonly_cond: assert property (s_cond_read(GRP_QUES) |=> (RD_DATA & 16'h06A3) == 16'h0000)
    else $error("event-only bits visible in condition view");
  a_cal_cond_read: assert property (s_cond_read(GRP_QUES) |=> RD_DATA[8] == $past(CAL_CORRUPT))
    else $error("calibration condition mismatch");
  a_unused_read_zero: assert property (RD_STB |=> (RD_DATA & ~grp_mask($past(RD_GROUP))) == 16'h0000)
    else $error("unused bit read as one");
  a_event_hold: assert property (st_reg.ev[2][0] && !CLS_STB && !(RD_STB && RD_VIEW == VIEW_EVENT)
                                 |=> st_reg.ev[2][0])
    else $error("event bit lost without clear");
  a_read_clears: assert property (RD_STB && RD_VIEW == VIEW_EVENT && RD_GROUP == GRP_ALRM && !ALARM_EVT[0]
                                  |=> !st_reg.ev[2][0] && RD_DATA[0] == $past(st_reg.ev[2][0]))
    else $error("event read did not return and clear");
  a_enable_write: assert property (WR_STB && WR_GROUP == GRP_OPER
                                   |=> st_reg.en[1] == ($past(WR_DATA) & MASK_OPER))
    else $error("enable mask not written");
  a_summary_ques: assert property (st_reg.ev[0][8] && st_reg.en[0][8] |-> SUM_QUES)
    else $error("questionable summary missing");
  a_cfg_panel_set: assert property (s_panel_first |=> s_panel_flagged)
    else $error("panel change not flagged");
  a_cond_rise: assert property ($rose(SCANNING) |=> st_reg.ev[1][4])
    else $error("condition rise not latched");
  a_threshold: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[9] == $past(over_thr))
    else $error("threshold condition mismatch");

  // ----------------------------------------
  // overload latching
  // ----------------------------------------
  a_curr_latch: assert property (s_ovl_armed(CURR_OVLD, st_reg.arm[1]) |=> st_reg.ev[0][1])
    else $error("current overload not latched");
  a_cap_latch: assert property (s_ovl_armed(CAP_OVLD, st_reg.arm[3]) |=> st_reg.ev[0][7])
    else $error("capacitance overload not latched");
  a_temp_latch: assert property (s_ovl_armed(TEMP_OVLD, st_reg.arm[5]) |=> st_reg.ev[0][10])
    else $error("temperature overload not latched");
  a_res_latch: assert property (s_ovl_armed(RES_OVLD, st_reg.arm[4]) |=> st_reg.ev[0][9])
    else $error("resistance overload not latched");
  a_init_rearm: assert property (INIT_CMD |=> st_reg.arm == RST_ARM)
    else $error("initiate did not re-arm overloads");
  a_arm_no_rise: assert property (!INIT_CMD |=> (st_reg.arm & ~$past(st_reg.arm)) == 6'h00)
    else $error("overload re-armed without initiate");

  // ----------------------------------------
  // condition views
  // ----------------------------------------
  a_lowlim_cond: assert property (s_cond_read(GRP_QUES) |=> RD_DATA[11] == $past(LOWER_LIMIT_FAIL))
    else $error("lower-limit condition mismatch");
  a_memovf_cond: assert property (s_cond_read(GRP_QUES) |=> RD_DATA[12] == $past(MEM_OVERFLOW))
    else $error("memory overflow condition mismatch");
  a_busy_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[1:0] == $past({SELF_TEST, CALIBRATING}))
    else $error("calibration or self-test condition mismatch");
  a_scan_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[5:4] == $past({WAIT_TRIG, SCANNING}))
    else $error("scan or trigger-wait condition mismatch");
  a_msd_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[7] == $past(MSD_DETECTED))
    else $error("storage drive condition mismatch");
  a_panel_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[8] == $past(st_reg.cfg_panel))
    else $error("panel change condition mismatch");
  a_lock_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[10] == $past(LOCKED))
    else $error("lock condition mismatch");
  a_errq_cond: assert property (s_cond_read(GRP_OPER) |=> RD_DATA[13] == $past(ERR_QUEUE_NE))
    else $error("error queue condition mismatch");
  a_oper_evonly: assert property (s_cond_read(GRP_OPER) |=> !RD_DATA[11])
    else $error("settings change visible in condition view");
  a_alarm_evonly: assert property (s_cond_read(GRP_ALRM) |=> (RD_DATA & 16'h002F) == 16'h0000)
    else $error("alarm event-only bits visible in condition view");
  a_aqueue_cond: assert property (s_cond_read(GRP_ALRM) |=> RD_DATA[4] == $past(ALARM_QUEUE_NE))
    else $error("alarm queue condition mismatch");
  a_trig_cond: assert property (s_cond_read(GRP_ALRM) |=> RD_DATA[8:6] == $past(ALARM_TRIGGERED))
    else $error("alarm triggered condition mismatch");

  // ----------------------------------------
  // event latching
  // ----------------------------------------
  a_cfg_clear: assert property ((MEAS_START || INIT_CMD) && !PANEL_CFG_CHANGE |=> !st_reg.cfg_panel)
    else $error("panel change flag not cleared by command");
  a_settings_evt: assert property (PANEL_CFG_CHANGE || REMOTE_CFG_CHANGE |=> st_reg.ev[1][11])
    else $error("settings change not latched");
  a_alarm_evt: assert property (ALARM_EVT != 4'h0
                                |=> (st_reg.ev[2][3:0] & $past(ALARM_EVT)) == $past(ALARM_EVT))
    else $error("alarm event not latched");
  a_aqueue_ovf: assert property (ALARM_QUEUE_OVF |=> st_reg.ev[2][5])
    else $error("alarm queue overflow not latched");
  a_cal_rise: assert property ($rose(CAL_CORRUPT) |=> st_reg.ev[0][8])
    else $error("calibration corrupt rise not latched");
  a_thr_rise: assert property ($rose(over_thr) |=> st_reg.ev[1][9])
    else $error("threshold rise not latched");
  a_aqueue_rise: assert property ($rose(ALARM_QUEUE_NE) |=> st_reg.ev[2][4])
    else $error("alarm queue rise not latched");
  a_cond_fall: assert property ($fell(SCANNING) && !st_reg.ev[1][4] |=> !st_reg.ev[1][4])
    else $error("condition fall latched an event");
  a_cls_clears: assert property (CLS_STB && !ALARM_EVT[1] |=> !st_reg.ev[2][1])
    else $error("clear-status left an event set");
  a_cond_read_keeps: assert property (s_cond_read(GRP_OPER) ##0 (st_reg.ev[1][4] && !CLS_STB)
                                      |=> st_reg.ev[1][4])
    else $error("condition read cleared an event");

  // ----------------------------------------
  // enables and summaries
  // ----------------------------------------
  a_enable_ques: assert property (WR_STB && WR_GROUP == GRP_QUES
                                  |=> st_reg.en[0] == ($past(WR_DATA) & MASK_QUES))
    else $error("questionable enable mask not written");
  a_write_none: assert property (WR_STB && WR_GROUP == 2'h3 |=> st_reg.en == $past(st_reg.en))
    else $error("write to no group changed a mask");
  a_unused_ev: assert property (((st_reg.ev[0] & ~MASK_QUES) | (st_reg.ev[1] & ~MASK_OPER)) == 16'h0000)
    else $error("unused event bit set");
  a_summary_oper: assert property (st_reg.ev[1][13] && st_reg.en[1][13] |-> SUM_OPER)
    else $error("operation summary missing");
  a_summary_alrm: assert property (st_reg.ev[2][5] && st_reg.en[2][5] |-> SUM_ALRM)
    else $error("alarm summary missing");
  a_summary_gate: assert property (st_reg.en[0] == 16'h0000 |-> !SUM_QUES)
    else $error("summary set with all enables off");
  a_read_answer: assert property (RD_STB |=> RD_VALID)
    else $error("read not answered");
  a_read_single: assert property (!RD_STB |=> !RD_VALID)
    else $error("read answer without request");

endmodule : iss_status_regs
`default_nettype wire

// [iss_pkg.sv]
package iss_pkg;
  localparam int          GW          = 16;
  localparam int          CNT_W       = 20;
  localparam logic [1:0]  GRP_QUES    = 2'h0;
  localparam logic [1:0]  GRP_OPER    = 2'h1;
  localparam logic [1:0]  GRP_ALRM    = 2'h2;
  localparam logic [1:0]  VIEW_COND   = 2'h0;
  localparam logic [1:0]  VIEW_EVENT  = 2'h1;
  localparam logic [1:0]  VIEW_ENABLE = 2'h2;
  // bits with a function in each group
  localparam logic [15:0] MASK_QUES   = 16'h1FA3;
  localparam logic [15:0] MASK_OPER   = 16'h2FB3;
  localparam logic [15:0] MASK_ALRM   = 16'h01FF;
  // bits that also have a live condition
  localparam logic [15:0] COND_QUES   = 16'h1900;
  localparam logic [15:0] COND_OPER   = 16'h27B3;
  localparam logic [15:0] COND_ALRM   = 16'h01D0;
  localparam logic [15:0] RST_ENABLE  = 16'h0000;
  localparam logic [5:0]  RST_ARM     = 6'h3F;
  localparam int          OVL_N       = 6;

  typedef struct packed {
    logic [2:0][15:0] ev;
    logic [2:0][15:0] en;
    logic [2:0][15:0] prev;
    logic [5:0]       arm;
    logic             cfg_panel;
    logic [15:0]      rd_data;
    logic             rd_valid;
  } iss_state_t;
endpackage : iss_pkg

// [iss_status_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module iss_status_regs_bench;
  import iss_pkg::*;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        rstn  = 1'b0;
  logic [5:0]  pl    = 6'h00;
  logic [5:0]  ovl   = 6'h00;
  logic [3:0]  aevt  = 4'h0;
  logic [2:0]  qc    = 3'h0;
  logic [6:0]  oc    = 7'h00;
  logic [19:0] cnt   = 20'h00000;
  logic [19:0] thr   = 20'h00000;
  logic        aqne  = 1'b0;
  logic [2:0]  atrig = 3'h0;
  logic        rd_stb = 1'b0;
  logic        wr_stb = 1'b0;
  logic [1:0]  rd_group = 2'h0;
  logic [1:0]  rd_view  = 2'h0;
  logic [1:0]  wr_group = 2'h0;
  logic [15:0] wr_data  = 16'h0000;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        sum_q;
  logic        sum_o;
  logic        sum_a;
  logic [15:0] expq[$];
  logic [31:0] r = 32'h9C9A0724;
  logic [31:0] c;
  logic [15:0] qx, ox, ax, wd;
  int          fail_count = 0;
  int          checked    = 0;

  always #10 clock = ~clock;

  // pl: init, measure, panel, remote, queue overflow, clear-status
  iss_status_regs u_dut (
    .CLOCK(clock), .RSTN(rstn), .INIT_CMD(pl[0]), .MEAS_START(pl[1]),
    .VOLT_OVLD(ovl[0]), .CURR_OVLD(ovl[1]), .FREQ_OVLD(ovl[2]), .CAP_OVLD(ovl[3]), .RES_OVLD(ovl[4]),
    .TEMP_OVLD(ovl[5]), .CAL_CORRUPT(qc[0]), .LOWER_LIMIT_FAIL(qc[1]), .MEM_OVERFLOW(qc[2]),
    .CALIBRATING(oc[0]), .SELF_TEST(oc[1]), .SCANNING(oc[2]), .WAIT_TRIG(oc[3]), .MSD_DETECTED(oc[4]),
    .LOCKED(oc[5]), .ERR_QUEUE_NE(oc[6]), .PANEL_CFG_CHANGE(pl[2]), .REMOTE_CFG_CHANGE(pl[3]),
    .STORED_COUNT(cnt), .READING_COUNT_THRESHOLD_SETTING(thr), .ALARM_EVT(aevt), .ALARM_QUEUE_NE(aqne),
    .ALARM_QUEUE_OVF(pl[4]), .ALARM_TRIGGERED(atrig), .RD_STB(rd_stb), .RD_GROUP(rd_group),
    .RD_VIEW(rd_view), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_STB(wr_stb), .WR_GROUP(wr_group),
    .WR_DATA(wr_data), .CLS_STB(pl[5]), .SUM_QUES(sum_q), .SUM_OPER(sum_o), .SUM_ALRM(sum_a));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic pulse(input logic [5:0] p, input logic [5:0] o, input logic [3:0] a);
    @(negedge clock);
    pl = p; ovl = o; aevt = a;
    @(negedge clock);
    pl = 6'h00; ovl = 6'h00; aevt = 4'h0;
  endtask : pulse

  task automatic rd(input logic [1:0] g, input logic [1:0] v, input logic [15:0] exp);
    @(negedge clock);
    rd_stb = 1'b1; rd_group = g; rd_view = v;
    expq.push_back(exp);
    @(negedge clock);
    rd_stb = 1'b0;
  endtask : rd

  task automatic wr(input logic [1:0] g, input logic [15:0] d);
    @(negedge clock);
    wr_stb = 1'b1; wr_group = g; wr_data = d;
    @(negedge clock);
    wr_stb = 1'b0;
  endtask : wr

  task automatic set_cond(input logic [31:0] x);
    @(negedge clock);
    qc = {x[12], x[11], x[8]};
    oc = {x[29], x[26], x[23], x[21], x[20], x[17], x[16]};
    cnt = x[19:0]; thr = x[31:12]; aqne = x[4]; atrig = x[8:6];
  endtask : set_cond

  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  // valid is a one-cycle pulse, so it is looked at mid-cycle
  always @(negedge clock) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() > 0) chk("rd_data", rd_data, expq.pop_front());
      else begin
        fail_count++;
        $display("BAD rd_valid expected none seen %h", rd_data);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    results();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock) rstn = 1'b1;
    for (int g = 0; g < 4; g++)
      for (int v = 0; v < 4; v++)
        rd(2'(g), 2'(v), 16'h0000);
    pulse(6'h00, 6'h3F, 4'h0);
    rd(GRP_QUES, VIEW_COND, 16'h0000);
    rd(GRP_QUES, VIEW_EVENT, 16'h06A3);
    pulse(6'h00, 6'h3F, 4'h0);
    rd(GRP_QUES, VIEW_EVENT, 16'h0000);
    pulse(6'h01, 6'h00, 4'h0);
    pulse(6'h00, 6'h21, 4'h0);
    rd(GRP_QUES, VIEW_EVENT, 16'h0401);
    pulse(6'h04, 6'h00, 4'h0);
    repeat (3) @(negedge clock);
    rd(GRP_OPER, VIEW_COND, 16'h0100);
    rd(GRP_OPER, VIEW_EVENT, 16'h0900);
    pulse(6'h02, 6'h00, 4'h0);
    rd(GRP_OPER, VIEW_COND, 16'h0000);
    pulse(6'h08, 6'h00, 4'h0);
    rd(GRP_OPER, VIEW_EVENT, 16'h0800);
    pulse(6'h10, 6'h00, 4'hF);
    rd(GRP_ALRM, VIEW_COND, 16'h0000);
    rd(GRP_ALRM, VIEW_EVENT, 16'h002F);
    pulse(6'h10, 6'h00, 4'h5);
    pulse(6'h00, 6'h01, 4'h0);
    pulse(6'h20, 6'h00, 4'h0);
    rd(GRP_ALRM, VIEW_EVENT, 16'h0000);
    rd(GRP_QUES, VIEW_EVENT, 16'h0000);
    // conditions start low each pass so every high level is a fresh rise
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      c = r;
      r = lfsr(r);
      wd = r[15:0];
      set_cond(c);
      repeat (3) @(negedge clock);
      qx = c[15:0] & 16'h1900;
      ox = (c[31:16] & 16'h24B3) | ((c[19:0] > c[31:12]) ? 16'h0200 : 16'h0000);
      ax = c[15:0] & 16'h01D0;
      rd(GRP_QUES, VIEW_COND, qx);
      rd(GRP_OPER, VIEW_COND, ox);
      rd(GRP_ALRM, VIEW_COND, ax);
      rd(GRP_OPER, VIEW_COND, ox);
      wr(GRP_QUES, wd);
      wr(GRP_OPER, ~wd);
      wr(GRP_ALRM, wd);
      wr(2'h3, 16'hFFFF);
      rd(GRP_QUES, VIEW_ENABLE, wd & MASK_QUES);
      rd(GRP_OPER, VIEW_ENABLE, ~wd & MASK_OPER);
      rd(GRP_ALRM, VIEW_ENABLE, wd & MASK_ALRM);
      chk("sum_ques", {15'h0000, sum_q}, {15'h0000, |(qx & wd)});
      chk("sum_oper", {15'h0000, sum_o}, {15'h0000, |(ox & ~wd)});
      chk("sum_alrm", {15'h0000, sum_a}, {15'h0000, |(ax & wd)});
      rd(GRP_QUES, VIEW_EVENT, qx);
      rd(GRP_OPER, VIEW_EVENT, ox);
      rd(GRP_ALRM, VIEW_EVENT, ax);
      chk("sums_cleared", {13'h0000, sum_q, sum_o, sum_a}, 16'h0000);
      set_cond(32'h00000000);
      repeat (3) @(negedge clock);
    end
    repeat (3) @(negedge clock);
    chk("pending_reads", 16'(expq.size()), 16'h0000);
    results();
  end
endmodule : iss_status_regs_bench
`default_nettype wire
